// File: verilog/token_bus_pkg.sv
// Shared constants and carrier types for the token bus station.
// Assumes a 50 MHz station clock and comparator outputs synchronous to it.
package token_bus_pkg;
  // ==========================================================
  // Clock and line rates
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = 50;
  localparam int BAUD_TOP = 153_600;
  localparam int BAUD_MID = 76_800;
  localparam int BAUD_LOW = 38_400;
  localparam int CNT_W = 16;
  // ==========================================================
  // Pulse filter limits, as fractions of the nominal pulse period
  localparam int NOMINAL_PULSE_PERIOD_CUS = 217;
  localparam int TP_TOP_CYC = NOMINAL_PULSE_PERIOD_CUS * CLK_MHZ / 100;
  localparam int HALF_MAX_NUM = 6;
  localparam int HALF_MAX_DEN = 10;
  localparam int TW_MIN_NUM = 188;
  localparam int TW_MIN_DEN = 1000;
  // ==========================================================
  // Character framing and token timing
  localparam int CHAR_BITS = 11;
  localparam int STOP_POS = CHAR_BITS - 1;
  localparam int PULSES_PER_BIT = 3;
  localparam int SEGS_PER_BIT = 2 * PULSES_PER_BIT;
  localparam int VOTE_ZERO = 2;
  localparam int ADDR_W = 5;
  localparam int CRC_W = 6;
  localparam int BCAST_POS = 7;
  localparam int SKIP_BITS_STD = 1;
  localparam int SKIP_BITS_EXT = 2;
  localparam int MIN_CHARS = 3;

  typedef enum logic [1:0] {
    RATE_LOW,
    RATE_MID,
    standard_top_rate,
    extended_top_rate
  } rate_t;
  typedef enum logic [1:0] {TK_LOAD, TK_WAIT, TK_COUNT} token_t;
  typedef enum logic [1:0] {TX_IDLE, TX_HEAD, TX_BODY, TX_TAIL} tx_phase_t;

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } bus_char_t;

  typedef struct packed {
    logic [ADDR_W-1:0] sender;
    logic broadcast;
  } frame_info_t;

  // ==========================================================
  // Per-rate cycle counts
  function automatic int rate_mult(rate_t r);
    case (r)
      RATE_LOW: return 4;
      RATE_MID: return 2;
      default: return 1;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] bit_cycles(rate_t r);
    return CNT_W'(CLK_HZ / BAUD_TOP * rate_mult(r));
  endfunction

  function automatic logic [CNT_W-1:0] half_max_cycles(rate_t r);
    return CNT_W'(TP_TOP_CYC * rate_mult(r) * HALF_MAX_NUM / HALF_MAX_DEN);
  endfunction

  function automatic logic [CNT_W-1:0] tw_min_cycles(rate_t r);
    return CNT_W'((TP_TOP_CYC * rate_mult(r) * TW_MIN_NUM + TW_MIN_DEN - 1)
                  / TW_MIN_DEN);
  endfunction
endpackage

// File: verilog/token_bus_station.sv
// Station logic for the half-duplex token bus: pulse filter, bit voting,
// character framing, CRC check, skip-time turn taking and transmitter.
// Assumes comparator and user inputs are synchronous to clk_sys_i.
`timescale 1ns/1ps

module token_bus_station #(
  parameter int MAX_CHARS = 64,
  parameter int ERR_LIMIT = 8,
  parameter logic [5:0] CRC_POLY = 6'h2F
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire token_bus_pkg::rate_t rate_i,
  input wire logic [token_bus_pkg::ADDR_W-1:0] station_bus_number_i,
  input wire logic pulse_pos_i,
  input wire logic pulse_neg_i,
  output logic drive_pos_o,
  output logic drive_neg_o,
  input wire logic tx_valid_i,
  input wire token_bus_pkg::bus_char_t tx_char_i,
  input wire logic tx_last_i,
  input wire logic tx_broadcast_i,
  output logic tx_ready_o,
  output logic tx_busy_o,
  output logic rx_valid_o,
  output token_bus_pkg::bus_char_t rx_char_o,
  output logic frame_ok_o,
  output logic frame_bad_o,
  output token_bus_pkg::frame_info_t frame_info_o,
  output logic rx_busy_o,
  output logic error_excess_o
);
  import token_bus_pkg::*;

  localparam int NW = $clog2(MAX_CHARS + 1);

  generate
    if (MAX_CHARS < MIN_CHARS || ERR_LIMIT < 1 || ERR_LIMIT > 255) begin : g_bad
      $error("token_bus_station: unsupported parameter values");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] pw;
    logic rx_on;
    logic [CNT_W-1:0] rx_bc;
    logic [1:0] votes;
    logic [3:0] rx_bn;
    logic [CHAR_BITS-1:0] rx_sh;
    logic [NW-1:0] nchar;
    logic rx_bad;
    bus_char_t held;
    logic [CRC_W-1:0] rx_crc;
    logic rx_bcast;
    logic [MAX_CHARS-1:0][8:0] buff;
    logic [NW-1:0] rd;
    logic [NW-1:0] dump_n;
    logic [ADDR_W-1:0] last_sender;
    token_t tk;
    logic [CNT_W-1:0] skip;
    tx_phase_t txp;
    logic [CHAR_BITS-1:0] tx_sh;
    logic [3:0] tx_bn;
    logic [CNT_W-1:0] tx_bc;
    logic [CNT_W-1:0] hc;
    logic [2:0] seg;
    logic [CRC_W-1:0] tx_crc;
    logic tx_last;
    logic drive_pos;
    logic drive_neg;
    logic rx_valid;
    bus_char_t rx_char;
    logic frame_ok;
    logic frame_bad;
    frame_info_t info;
    logic [7:0] err_cnt;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Serial CRC, least significant data bit first.
  function automatic logic [CRC_W-1:0] crc_fold(logic [CRC_W-1:0] c, logic [7:0] d);
    logic fb;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[CRC_W-1] ^ d[i];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    return c;
  endfunction

  // ==========================================================
  // Next state
  logic [CNT_W-1:0] bitc;
  logic [CNT_W-1:0] halfc;
  logic pulse_end;
  logic good_pulse;
  logic rx_bit;
  logic bit_end;
  logic tx_bit_end;
  logic boundary;
  bus_char_t got;
  logic [ADDR_W:0] diff;
  logic [CNT_W-1:0] unit;

  always_comb begin
    s_nxt = s_r;
    bitc = bit_cycles(rate_i);
    halfc = CNT_W'(bitc / CNT_W'(SEGS_PER_BIT));
    got = '0;
    diff = '0;
    unit = '0;
    s_nxt.rx_valid = 1'b0;
    s_nxt.frame_ok = 1'b0;
    s_nxt.frame_bad = 1'b0;

    // Width of the current excursion beyond either threshold.
    pulse_end = (s_r.pw != '0) && !(pulse_pos_i || pulse_neg_i);
    if (pulse_pos_i ^ pulse_neg_i) begin
      s_nxt.pw = s_r.pw + 1'b1;
    end else begin
      s_nxt.pw = '0;
    end
    // Own echo is ignored so the station never decodes itself.
    good_pulse = pulse_end && (s_r.txp == TX_IDLE)
                 && (s_r.pw >= tw_min_cycles(rate_i))
                 && (s_r.pw <= half_max_cycles(rate_i));

    // ========================================================
    // Bit recovery: first pulse aligns the bit clock.
    bit_end = s_r.rx_on && (s_r.rx_bc >= bitc - 1'b1);
    rx_bit = (s_r.votes < 2'(VOTE_ZERO));
    if (!s_r.rx_on) begin
      if (good_pulse) begin
        s_nxt.rx_on = 1'b1;
        s_nxt.rx_bc = s_r.pw;
        s_nxt.votes = 2'd1;
        s_nxt.rx_bn = '0;
      end
    end else if (bit_end) begin
      s_nxt.rx_bc = '0;
      s_nxt.votes = good_pulse ? 2'd1 : 2'd0;
      if (s_r.rx_bn == '0 && rx_bit) begin
        // Idle bit where a start bit was due: the frame is over.
        s_nxt.rx_on = 1'b0;
        if (s_r.nchar != '0) begin
          if (!s_r.rx_bad && s_r.nchar >= NW'(MIN_CHARS) && s_r.held.ctrl
              && s_r.held.data[CRC_W-1:0] == s_r.rx_crc) begin
            s_nxt.frame_ok = 1'b1;
            s_nxt.rd = '0;
            s_nxt.dump_n = s_r.nchar - 1'b1;
            s_nxt.err_cnt = (s_r.err_cnt != '0) ? s_r.err_cnt - 1'b1 : '0;
          end else begin
            s_nxt.frame_bad = 1'b1;
            s_nxt.err_cnt = (s_r.err_cnt != 8'hFF) ? s_r.err_cnt + 1'b1 : s_r.err_cnt;
          end
          s_nxt.info.sender = s_r.last_sender;
          s_nxt.info.broadcast = s_r.rx_bcast;
          s_nxt.tk = TK_LOAD;
        end
        s_nxt.nchar = '0;
        s_nxt.rx_bad = 1'b0;
      end else begin
        s_nxt.rx_sh = {rx_bit, s_r.rx_sh[CHAR_BITS-1:1]};
        s_nxt.rx_bn = s_r.rx_bn + 1'b1;
        if (s_r.rx_bn == 4'(STOP_POS)) begin
          s_nxt.rx_bn = '0;
          got = {s_nxt.rx_sh[1], s_nxt.rx_sh[9:2]};
          if (!rx_bit || s_nxt.rx_sh[0]) begin
            s_nxt.rx_bad = 1'b1;
          end
          if (s_r.nchar == '0) begin
            s_nxt.rx_crc = '0;
            if (!got.ctrl) begin
              s_nxt.rx_bad = 1'b1;
            end else begin
              s_nxt.last_sender = got.data[ADDR_W-1:0];
              s_nxt.rx_bcast = got.data[BCAST_POS];
            end
          end else begin
            s_nxt.rx_crc = crc_fold(s_r.rx_crc, s_r.held.data);
          end
          // Block markers are kept as ordinary characters.
          if (s_r.nchar == NW'(MAX_CHARS)) begin
            s_nxt.rx_bad = 1'b1;
          end else begin
            s_nxt.buff[s_r.nchar] = got;
            s_nxt.nchar = s_r.nchar + 1'b1;
          end
          s_nxt.held = got;
        end
      end
    end else begin
      s_nxt.rx_bc = s_r.rx_bc + 1'b1;
      if (good_pulse && s_r.votes != 2'd3) begin
        s_nxt.votes = s_r.votes + 1'b1;
      end
    end

    // Accepted frames, less the closing CRC character, are replayed one character per clock; the replay
    // ends long before the next character can land in the buffer.
    if (s_r.dump_n != '0) begin
      s_nxt.rx_valid = 1'b1;
      s_nxt.rx_char = s_r.buff[s_r.rd];
      s_nxt.rd = s_r.rd + 1'b1;
      s_nxt.dump_n = s_r.dump_n - 1'b1;
    end

    // ========================================================
    // Turn taking
    case (s_r.tk)
      TK_LOAD: begin
        diff = {1'b0, station_bus_number_i - s_r.last_sender};
        if (diff == '0) begin
          diff = (ADDR_W + 1)'(1 << ADDR_W);
        end
        unit = (rate_i == extended_top_rate) ? CNT_W'(bitc * SKIP_BITS_EXT)
                                             : CNT_W'(bitc * SKIP_BITS_STD);
        s_nxt.skip = CNT_W'(unit * diff);
        s_nxt.tk = TK_COUNT;
      end
      TK_COUNT: begin
        if (s_r.rx_on || good_pulse) begin
          s_nxt.tk = TK_WAIT;
        end else if (s_r.skip <= 1) begin
          s_nxt.tk = TK_WAIT;
          if (tx_valid_i && s_r.txp == TX_IDLE) begin
            s_nxt.txp = TX_HEAD;
            s_nxt.tx_sh = {1'b1, tx_broadcast_i, 2'b00,
                           station_bus_number_i, 1'b1, 1'b0};
            s_nxt.tx_crc = crc_fold('0, {tx_broadcast_i, 2'b00, station_bus_number_i});
            s_nxt.tx_bn = '0;
            s_nxt.tx_bc = '0;
            s_nxt.hc = '0;
            s_nxt.seg = '0;
            s_nxt.tx_last = 1'b0;
          end
        end else begin
          s_nxt.skip = s_r.skip - 1'b1;
        end
      end
      TK_WAIT: begin
      end
      default: s_nxt.tk = TK_WAIT;
    endcase

    // ========================================================
    // Transmitter
    tx_bit_end = (s_r.txp != TX_IDLE) && (s_r.tx_bc >= bitc - 1'b1);
    boundary = tx_bit_end && (s_r.tx_bn == 4'(STOP_POS));
    tx_ready_o = boundary && (s_r.txp != TX_TAIL) && !s_r.tx_last;
    if (s_r.txp != TX_IDLE) begin
      s_nxt.tx_bc = s_r.tx_bc + 1'b1;
      if (s_r.hc >= halfc - 1'b1) begin
        s_nxt.hc = '0;
        s_nxt.seg = (s_r.seg < 3'(SEGS_PER_BIT)) ? s_r.seg + 1'b1 : s_r.seg;
      end else begin
        s_nxt.hc = s_r.hc + 1'b1;
      end
      if (tx_bit_end) begin
        s_nxt.tx_bc = '0;
        s_nxt.hc = '0;
        s_nxt.seg = '0;
        s_nxt.tx_bn = s_r.tx_bn + 1'b1;
        s_nxt.tx_sh = {1'b1, s_r.tx_sh[CHAR_BITS-1:1]};
      end
      if (boundary) begin
        s_nxt.tx_bn = '0;
        if (s_r.txp == TX_TAIL) begin
          s_nxt.txp = TX_IDLE;
          s_nxt.last_sender = station_bus_number_i;
          s_nxt.tk = TK_LOAD;
        end else if (tx_ready_o && tx_valid_i) begin
          s_nxt.txp = TX_BODY;
          s_nxt.tx_sh = {1'b1, tx_char_i.data, tx_char_i.ctrl, 1'b0};
          s_nxt.tx_crc = crc_fold(s_r.tx_crc, tx_char_i.data);
          s_nxt.tx_last = tx_last_i;
        end else begin
          s_nxt.txp = TX_TAIL;
          s_nxt.tx_sh = {1'b1, 2'b00, s_r.tx_crc, 1'b1, 1'b0};
        end
      end
    end
    // Each zero bit is a negative then positive half, three times.
    s_nxt.drive_neg = (s_r.txp != TX_IDLE) && !s_r.tx_sh[0]
                      && (s_r.seg < 3'(SEGS_PER_BIT)) && !s_r.seg[0];
    s_nxt.drive_pos = (s_r.txp != TX_IDLE) && !s_r.tx_sh[0]
                      && (s_r.seg < 3'(SEGS_PER_BIT)) && s_r.seg[0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.tk <= TK_LOAD;
      s_r.txp <= TX_IDLE;
      s_r.last_sender <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign drive_pos_o = s_r.drive_pos;
  assign drive_neg_o = s_r.drive_neg;
  assign tx_busy_o = (s_r.txp != TX_IDLE);
  assign rx_valid_o = s_r.rx_valid;
  assign rx_char_o = s_r.rx_char;
  assign frame_ok_o = s_r.frame_ok;
  assign frame_bad_o = s_r.frame_bad;
  assign frame_info_o = s_r.info;
  assign rx_busy_o = s_r.rx_on;
  assign error_excess_o = (s_r.err_cnt >= 8'(ERR_LIMIT));
endmodule // token_bus_station

// File: test/token_bus_station_sva.sv
// Port checks for the token bus station: drive pulse shape and frame answers.
// Assumes binding to token_bus_station; pulse widths are judged at top rates only.
`timescale 1ns/1ps

module token_bus_station_sva
  import token_bus_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire token_bus_pkg::rate_t rate_i,
  input wire logic drive_pos_o,
  input wire logic drive_neg_o,
  input wire logic tx_ready_o,
  input wire logic tx_busy_o,
  input wire logic rx_valid_o,
  input wire token_bus_pkg::bus_char_t rx_char_o,
  input wire logic frame_ok_o,
  input wire logic frame_bad_o,
  input wire token_bus_pkg::frame_info_t frame_info_o
);
  // ==========================================================
  // Helper logic
  // Half pulses outlast any repetition count, so a run counter measures them.
  localparam int HALF = TP_TOP_CYC / 2;
  logic [1:0] drv_r;
  logic [15:0] run_r;
  logic top_w;
  assign top_w = (rate_i == standard_top_rate) || (rate_i == extended_top_rate);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_r <= 2'b00;
      run_r <= 16'h0000;
    end else begin
      drv_r <= {drive_pos_o, drive_neg_o};
      run_r <= ({drive_pos_o, drive_neg_o} == drv_r) ? run_r + 16'h0001 : 16'h0001;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_neg_end; $fell(drive_neg_o) && top_w; endsequence
  sequence s_pos_end; $fell(drive_pos_o) && top_w; endsequence
  sequence s_rx_head;
    rx_valid_o && rx_char_o.ctrl && rx_char_o.data[7] == frame_info_o.broadcast
      && rx_char_o.data[4:0] == frame_info_o.sender;
  endsequence
  property p_drive_excl; !(drive_pos_o && drive_neg_o); endproperty
  property p_drive_busy; (drive_pos_o || drive_neg_o) |-> tx_busy_o; endproperty
  property p_neg_width; s_neg_end |-> run_r == 16'(HALF) && drive_pos_o; endproperty
  property p_pos_width; s_pos_end |-> run_r == 16'(HALF); endproperty
  property p_ok_head; frame_ok_o |=> s_rx_head ##1 rx_valid_o; endproperty
  property p_ok_bad; !(frame_ok_o && frame_bad_o); endproperty
  property p_bad_quiet; frame_bad_o |=> (!rx_valid_o) [*2]; endproperty
  property p_ready_gap; tx_ready_o |=> (!tx_ready_o) [*8]; endproperty
  property p_ready_busy; tx_ready_o |-> tx_busy_o; endproperty
  a_drive_excl: assert property (p_drive_excl) else $error("drives overlap");
  a_drive_busy: assert property (p_drive_busy) else $error("drive while idle");
  a_neg_width: assert property (p_neg_width) else $error("negative half width");
  a_pos_width: assert property (p_pos_width) else $error("positive half width");
  a_ok_head: assert property (p_ok_head) else $error("bad frame head");
  a_ok_bad: assert property (p_ok_bad) else $error("ok and bad together");
  a_bad_quiet: assert property (p_bad_quiet) else $error("rejected frame data");
  a_ready_gap: assert property (p_ready_gap) else $error("ready too close");
  a_ready_busy: assert property (p_ready_busy) else $error("ready while idle");
endmodule // token_bus_station_sva

// File: test/token_bus_peer.sv
// Peer station model: sends frames as comparator pulses, decodes station drives.
// Assumes the top rate bit timing; comparators idle low when nobody transmits.
`timescale 1ns/1ps

module token_bus_peer
  import token_bus_pkg::*;
#(
  parameter logic [5:0] CRC_POLY = 6'h2F
) (
  input wire logic clk_i,
  input wire logic drv_pos_i,
  input wire logic drv_neg_i,
  output logic pos_o,
  output logic neg_o
);
  localparam int HALF = TP_TOP_CYC / 2;
  localparam int BIT = CLK_HZ / BAUD_TOP;
  // Both comparators rest low at the end of every half, as the line swings through the
  // dead band. Without the rest the receiver would see one long excursion per bit.
  localparam int GAP = 8;
  logic [10:0] rx_w [0:2];

  initial begin
    pos_o = 1'b0;
    neg_o = 1'b0;
  end

  // ==========================================================
  // Frame building
  function automatic logic [5:0] crc6(input logic [7:0] a, input logic [7:0] b);
    logic [5:0] c;
    logic [15:0] s;
    c = 6'h00;
    s = {b, a};
    for (int i = 0; i < 16; i++) begin
      c = {c[4:0], 1'b0} ^ ((c[5] ^ s[i]) ? CRC_POLY : 6'h00);
    end
    return c;
  endfunction

  // A miss drops the third pulse so the receiver must vote.
  task automatic send_bit(input logic b, input logic miss);
    for (int p = 0; p < 6; p++) begin
      neg_o = !b && (p % 2 == 0) && !(miss && p >= 4);
      pos_o = !b && (p % 2 == 1) && !(miss && p >= 4);
      repeat (HALF - GAP) @(posedge clk_i);
      #1;
      neg_o = 1'b0;
      pos_o = 1'b0;
      repeat (GAP) @(posedge clk_i);
      #1;
    end
    repeat (BIT - 6 * HALF) @(posedge clk_i);
    #1;
  endtask

  task automatic send_char(input logic ctrl, input logic [7:0] d, input logic miss);
    logic [10:0] w;
    w = {1'b1, d, ctrl, 1'b0};
    for (int i = 0; i < 11; i++) send_bit(w[i], miss);
  endtask

  task automatic send_frame(input logic [4:0] a, input logic bc, input logic [7:0] d,
                            input logic bad, input logic miss);
    logic [7:0] h;
    h = {bc, 2'b00, a};
    send_char(1'b1, h, miss);
    send_char(1'b0, d, miss);
    send_char(1'b1, {2'b00, crc6(h, d) ^ {6{bad}}}, miss);
  endtask

  task automatic send_glitch(input int w);
    pos_o = 1'b1;
    repeat (w) @(posedge clk_i);
    #1;
    pos_o = 1'b0;
    repeat (BIT) @(posedge clk_i);
    #1;
  endtask

  // ==========================================================
  // Decoding: any drive activity inside a bit window makes it a zero.
  task automatic recv_frame();
    logic z;
    for (int t = 0; t < 4000 && drv_neg_i !== 1'b1; t++) begin
      @(posedge clk_i);
      #1;
    end
    for (int k = 0; k < 33; k++) begin
      z = 1'b0;
      repeat (BIT) begin
        z = z | drv_pos_i | drv_neg_i;
        @(posedge clk_i);
        #1;
      end
      rx_w[k / 11][k % 11] = !z;
    end
  endtask
endmodule // token_bus_peer

// File: test/tb_token_bus_station.sv
// Self-checking bench: one station against a peer model on the pulse pins.
// Assumes the package, station, peer model and checker are compiled first.
`timescale 1ns/1ps

module tb_token_bus_station;
  import token_bus_pkg::*;
  localparam int BIT = CLK_HZ / BAUD_TOP;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  rate_t rate = standard_top_rate;
  logic pls_pos, pls_neg, drv_pos, drv_neg, tx_ready, tx_busy, rx_valid;
  logic frame_ok, frame_bad, rx_busy, err_excess;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic tx_bc = 1'b0;
  logic [4:0] own = 5'd5;
  bus_char_t tx_char = '0;
  bus_char_t rx_char;
  frame_info_t info;
  bus_char_t rxq[$];
  int n_errors = 0;
  int n_checks = 0;
  int n_ok = 0;
  int n_bad = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  token_bus_station #(.ERR_LIMIT(2)) dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .rate_i(rate), .station_bus_number_i(own),
    .pulse_pos_i(pls_pos), .pulse_neg_i(pls_neg), .drive_pos_o(drv_pos), .drive_neg_o(drv_neg),
    .tx_valid_i(tx_valid), .tx_char_i(tx_char), .tx_last_i(tx_last), .tx_broadcast_i(tx_bc),
    .tx_ready_o(tx_ready), .tx_busy_o(tx_busy), .rx_valid_o(rx_valid), .rx_char_o(rx_char),
    .frame_ok_o(frame_ok), .frame_bad_o(frame_bad), .frame_info_o(info), .rx_busy_o(rx_busy),
    .error_excess_o(err_excess));

  token_bus_peer peer (.clk_i(clk_sys_i), .drv_pos_i(drv_pos), .drv_neg_i(drv_neg),
    .pos_o(pls_pos), .neg_o(pls_neg));

  always @(posedge clk_sys_i) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_char);
    if (frame_ok === 1'b1) n_ok++;
    if (frame_bad === 1'b1) n_bad++;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Frame answers come about a bit after the stop bit; the settle lets rx data land.
  task automatic wait_frame();
    int n0;
    n0 = n_ok + n_bad;
    for (int t = 0; t < 3 * BIT && n_ok + n_bad == n0; t++) begin
      @(posedge clk_sys_i);
      #1;
    end
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_glitch();
    peer.send_glitch(20);
    check(32'(rx_busy), 32'd0);
    peer.send_glitch(65);
    check(32'(rx_busy), 32'd0);
  endtask

  task automatic t_bad();
    repeat (2) begin
      peer.send_frame(5'd7, 1'b0, 8'h3C, 1'b1, 1'b0);
      wait_frame();
    end
    check(n_bad, 32'd2);
    check(rxq.size(), 32'd0);
    check(32'(err_excess), 32'd1);
  endtask

  // The peer ends a frame; the station sits two addresses later, wrapping past 31 if needed.
  task automatic t_turn(input rate_t r, input logic bc, input logic miss, input int skip,
                        input logic [4:0] me, input logic [4:0] snd);
    int t;
    logic [7:0] h;
    rate = r;
    own = me;
    tx_bc = bc;
    rxq.delete();
    n_ok = 0;
    t = 0;
    h = {bc, 2'b00, me};
    peer.send_frame(snd, 1'b0, 8'h5A, 1'b0, miss);
    wait_frame();
    tx_valid = 1'b1;
    tx_char = {1'b0, 8'hA5};
    tx_last = 1'b1;
    check(n_ok, 32'd1);
    check(32'(info), 32'({snd, 1'b0}));
    check(32'(rxq[0]), 32'({1'b1, 3'b000, snd}));
    check(32'(rxq[1]), 32'h0000_005A);
    check(32'(err_excess), 32'd0);
    fork
      peer.recv_frame();
      begin
        while (tx_busy !== 1'b1 && t < 3000) begin
          @(posedge clk_sys_i);
          #1;
          t++;
        end
        check(32'(t >= (2 * skip - 1) * BIT && t <= (2 * skip + 1) * BIT), 32'd1);
        for (int k = 0; k < 30 * BIT && tx_ready !== 1'b1; k++) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        tx_valid = 1'b0;
        tx_last = 1'b0;
      end
    join
    check(32'(peer.rx_w[0]), 32'({1'b1, h, 1'b1, 1'b0}));
    check(32'(peer.rx_w[1]), 32'({1'b1, 8'hA5, 2'b00}));
    check(32'(peer.rx_w[2]), 32'({1'b1, 2'b00, peer.crc6(h, 8'hA5), 2'b10}));
    repeat (2 * BIT) @(posedge clk_sys_i);
    #1;
    check(32'(tx_busy), 32'd0);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    t_glitch();
    t_bad();
    t_turn(standard_top_rate, 1'b0, 1'b0, SKIP_BITS_STD, 5'd5, 5'd3);
    t_turn(extended_top_rate, 1'b1, 1'b1, SKIP_BITS_EXT, 5'd1, 5'd31);
    finish_test();
  end
endmodule // tb_token_bus_station

bind token_bus_station token_bus_station_sva u_sva (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .rate_i(rate_i), .drive_pos_o(drive_pos_o), .drive_neg_o(drive_neg_o),
  .tx_ready_o(tx_ready_o), .tx_busy_o(tx_busy_o), .rx_valid_o(rx_valid_o),
  .rx_char_o(rx_char_o), .frame_ok_o(frame_ok_o), .frame_bad_o(frame_bad_o),
  .frame_info_o(frame_info_o));
